//--- core/hhq_qualifier.sv
// Purpose: Decides when the holdover tuning word history averager runs, pauses or clears.
// Assumes: Loop status inputs are synchronous to clk; APB slave answers with no wait state.
// Notes:   A zero accumulation timer still needs one counted millisecond of running before availability.
`timescale 1ns/1ps
module hhq_qualifier
   import hhq_pkg::*;
#(
   parameter int MsCycles = MS_CYCLES
) (
   input  wire logic              clk,
   input  wire logic              reset_n,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire logic              freqLockIn,
   input  wire logic              phaseLockIn,
   input  wire logic              slewingIn,
   input  wire logic              slewLimitIn,
   input  wire logic              holdoverIn,
   input  wire logic [TW_W-1:0]   tuningWordIn,
   input  wire logic [TW_W-1:0]   avgWordIn,
   output logic                   histRun,
   output logic                   histPause,
   output logic                   histClear,
   output logic                   histAvail,
   output logic                   useLatest,
   output logic [TW_W-1:0]        holdoverWord
);

   function automatic logic hitIdx(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
      hitIdx = (a[ADDR_W-1:2] == idx[ADDR_W-3:0]) && (a[1:0] == 2'h0);
   endfunction

   logic [1:0]       rstSync_q;
   logic             rstN;
   logic [4:0]       startOpts_q;
   logic [2:0]       pauseCtrl_q;
   logic [7:0]       holdOff_q;
   logic [ACC_W-1:0] accTimer_q;
   logic [31:0]      prdata_q;
   logic             err_q;
   hhq_state_t       state_q;
   hhq_state_t       state_d;
   logic [16:0]      msCnt_q;
   logic [7:0]       holdCnt_q;
   logic [ACC_W-1:0] accCnt_q;
   logic             avail_q;
   logic             qual_q;
   logic             pause_q;
   logic             holdover_q;
   logic             clear_q;
   logic [TW_W-1:0]  holdWord_q;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rstSync_q <= 2'h0;
      end else begin
         rstSync_q <= {rstSync_q[0], 1'b1};
      end
   end
   assign rstN = rstSync_q[1];

   // Register decode.
   wire setup    = psel && !penable;
   wire wrAccess = psel && penable && pwrite;
   wire hitStat  = hitIdx(paddr, IDX_STATUS);
   wire hitAcc   = hitIdx(paddr, IDX_ACC_TIMER);
   wire hitStart = hitIdx(paddr, IDX_START_OPTS);
   wire hitPause = hitIdx(paddr, IDX_PAUSE_CTRL);
   wire hitHold  = hitIdx(paddr, IDX_HOLD_OFF);
   wire hitAny   = hitStat || hitAcc || hitStart || hitPause || hitHold;
   wire writeBad = pwrite && hitStat;
   wire [31:0] rdMux = hitAcc   ? {4'h0, accTimer_q} :
                       hitStart ? {27'h0, startOpts_q} :
                       hitPause ? {29'h0, pauseCtrl_q} :
                       hitHold  ? {24'h0, holdOff_q} :
                       hitStat  ? {26'h0, avail_q, state_q, histPause, histRun} : 32'h0;

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         prdata_q <= 32'h0;
         err_q    <= 1'b0;
      end else if (setup) begin
         prdata_q <= rdMux;
         err_q    <= !hitAny || writeBad;
      end
   end
   assign prdata  = prdata_q;
   assign pready  = 1'b1;
   assign pslverr = psel && penable && err_q;

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         startOpts_q <= START_RESET;
         pauseCtrl_q <= PAUSE_RESET;
         holdOff_q   <= HOLD_RESET;
         accTimer_q  <= ACC_RESET;
      end else if (wrAccess) begin
         if (hitStart) startOpts_q <= pwdata[4:0];
         if (hitPause) pauseCtrl_q <= pwdata[2:0];
         if (hitHold)  holdOff_q   <= pwdata[7:0];
         if (hitAcc)   accTimer_q  <= pwdata[ACC_W-1:0];
      end
   end

   wire persist    = startOpts_q[SO_PERSIST];
   wire singleSamp = startOpts_q[SO_SINGLE];
   wire quickStart = startOpts_q[SO_QUICK];
   wire waitPhase  = startOpts_q[SO_WAIT_PHASE];
   wire waitFreq   = startOpts_q[SO_WAIT_FREQ];

   wire qual    = (!waitPhase || phaseLockIn) && (!waitFreq || freqLockIn) && !holdoverIn;
   wire qualNew = qual && !qual_q;

   wire pauseNow = (pauseCtrl_q[PC_SLEWING] && slewingIn) ||
                   (pauseCtrl_q[PC_FREQ_UNLK] && !freqLockIn) ||
                   (pauseCtrl_q[PC_PHASE_UNLK] && slewLimitIn);

   wire msTick  = (msCnt_q == 17'(MsCycles - 1));
   wire holdEnd = (holdCnt_q == holdOff_q);
   wire [ACC_W-1:0] accTarget = quickStart ? (accTimer_q >> 2) : accTimer_q;

   wire clearNow = !persist && ((pause_q && !pauseNow && state_q == HHQ_RUN) ||
                                (holdover_q && !holdoverIn));

   always_comb begin
      state_d = state_q;
      unique case (state_q)
         HHQ_IDLE: begin
            if (qual) state_d = (holdOff_q == 8'h00) ? HHQ_RUN : HHQ_HOLD;
         end
         HHQ_HOLD: begin
            if (!qual) state_d = HHQ_IDLE;
            else if (holdEnd) state_d = HHQ_RUN;
         end
         HHQ_RUN: begin
            if (holdoverIn) state_d = HHQ_IDLE;
         end
         default: state_d = HHQ_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         state_q    <= HHQ_IDLE;
         qual_q     <= 1'b0;
         pause_q    <= 1'b0;
         holdover_q <= 1'b0;
         clear_q    <= 1'b0;
      end else begin
         state_q    <= state_d;
         qual_q     <= qual;
         pause_q    <= pauseNow;
         holdover_q <= holdoverIn;
         clear_q    <= clearNow;
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         msCnt_q   <= 17'h0;
         holdCnt_q <= 8'h0;
      end else begin
         msCnt_q   <= (qualNew || msTick) ? 17'h0 : msCnt_q + 17'h1;
         if (state_q != HHQ_HOLD) holdCnt_q <= 8'h0;
         else if (msTick && !holdEnd) holdCnt_q <= holdCnt_q + 8'h1;
      end
   end

   assign histRun   = (state_q == HHQ_RUN) && !holdoverIn && !pauseNow;
   assign histPause = (state_q == HHQ_RUN) && pauseNow;
   assign histClear = clear_q;

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         accCnt_q <= '0;
         avail_q  <= 1'b0;
      end else if (clearNow) begin
         accCnt_q <= '0;
         avail_q  <= 1'b0;
      end else begin
         if (histRun && msTick && !avail_q) accCnt_q <= accCnt_q + 28'h1;
         if (accCnt_q >= accTarget && accCnt_q != 28'h0) avail_q <= 1'b1;
      end
   end
   assign histAvail = avail_q;

   assign useLatest = holdoverIn && !avail_q && singleSamp;
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         holdWord_q <= '0;
      end else begin
         holdWord_q <= useLatest ? tuningWordIn : avgWordIn;
      end
   end
   assign holdoverWord = holdWord_q;

   // Checks beside the logic.
   AST_WAIT_PHASE: assert property (@(posedge clk) disable iff (!rstN)
      (state_q == HHQ_IDLE && waitPhase && !phaseLockIn) |=> state_q == HHQ_IDLE)
      else $error("Start left idle without phase lock.");
   AST_WAIT_FREQ: assert property (@(posedge clk) disable iff (!rstN)
      (state_q == HHQ_IDLE && waitFreq && !freqLockIn) |=> state_q == HHQ_IDLE)
      else $error("Start left idle without frequency lock.");
   AST_NO_PHASE_WAIT: assert property (@(posedge clk) disable iff (!rstN)
      (state_q == HHQ_IDLE && !waitPhase && !waitFreq && !holdoverIn) |=> state_q != HHQ_IDLE)
      else $error("Start held although no lock wait is set.");
   AST_HOLDOFF_ZERO: assert property (@(posedge clk) disable iff (!rstN)
      (state_q == HHQ_IDLE && qual && holdOff_q == 8'h00) |=> state_q == HHQ_RUN)
      else $error("Zero hold off did not start averaging at once.");
   AST_HOLDOFF_QUIET: assert property (@(posedge clk) disable iff (!rstN)
      (state_q == HHQ_HOLD) |-> !histRun)
      else $error("Averaging ran during hold off.");
   AST_SLEW_PAUSE: assert property (@(posedge clk) disable iff (!rstN)
      (pauseCtrl_q[PC_SLEWING] && slewingIn) |-> !histRun)
      else $error("Averaging ran while slewing with pause set.");
   AST_SLEW_IGNORED: assert property (@(posedge clk) disable iff (!rstN)
      (state_q == HHQ_RUN && !holdoverIn && pauseCtrl_q == 3'h0) |-> histRun)
      else $error("Averaging stopped with no pause source enabled.");
   AST_PERSIST: assert property (@(posedge clk) disable iff (!rstN)
      ($past(persist) && persist) |-> !histClear)
      else $error("History cleared while persistent.");
   AST_HOLDOVER_CLEAR: assert property (@(posedge clk) disable iff (!rstN)
      ($fell(holdoverIn) && !persist) |=> histClear)
      else $error("History not cleared on holdover exit.");
   AST_SINGLE_SAMPLE: assert property (@(posedge clk) disable iff (!rstN)
      useLatest |=> holdoverWord == $past(tuningWordIn))
      else $error("Holdover word is not the latest tuning word.");

   // Pause sources and clearing are checked apart, so one broken term cannot hide behind another.
   AST_FREQ_PAUSE: assert property (@(posedge clk) disable iff (!rstN)
      (pauseCtrl_q[PC_FREQ_UNLK] && !freqLockIn) |-> !histRun)
      else $error("Averaging ran without frequency lock with pause set.");

   AST_LIMIT_PAUSE: assert property (@(posedge clk) disable iff (!rstN)
      (pauseCtrl_q[PC_PHASE_UNLK] && slewLimitIn) |-> !histRun)
      else $error("Averaging ran while slew limited with pause set.");

   AST_PAUSE_CLEAR: assert property (@(posedge clk) disable iff (!rstN)
      (!persist && pause_q && !pauseNow && state_q == HHQ_RUN) |=> histClear)
      else $error("History not cleared when a pause ended.");

   AST_RUN_EXCL: assert property (@(posedge clk) disable iff (!rstN)
      !(histRun && histPause))
      else $error("Run and pause raised together.");

   AST_PAUSE_IN_RUN: assert property (@(posedge clk) disable iff (!rstN)
      histPause |-> state_q == HHQ_RUN)
      else $error("Pause raised outside the running state.");

   AST_CLEAR_AVAIL: assert property (@(posedge clk) disable iff (!rstN)
      histClear |-> !histAvail)
      else $error("History still available while being cleared.");

   AST_AVAIL_TARGET: assert property (@(posedge clk) disable iff (!rstN)
      $rose(histAvail) |-> accCnt_q >= accTarget)
      else $error("History available before the accumulation target.");

   AST_TICK_RESTART: assert property (@(posedge clk) disable iff (!rstN)
      qualNew |=> msCnt_q == 17'h0)
      else $error("Millisecond tick did not restart on new qualification.");

   AST_HOLD_STAY: assert property (@(posedge clk) disable iff (!rstN)
      (state_q == HHQ_HOLD && qual && !holdEnd) |=> state_q == HHQ_HOLD)
      else $error("Hold off ended early.");

   AST_HOLDOVER_IDLE: assert property (@(posedge clk) disable iff (!rstN)
      holdoverIn |=> state_q == HHQ_IDLE)
      else $error("Averaging state kept during holdover.");
endmodule

//--- core/hhq_pkg.sv
// Purpose: Shared constants for the holdover history qualifier.
// Assumes: 100 MHz system clock and a 32-bit APB register port.
// Notes:   Register indices are word indices; byte address is four times the index.
package hhq_pkg;
   localparam logic [15:0] IDX_STATUS     = 16'h1408;
   localparam logic [15:0] IDX_ACC_TIMER  = 16'h140a;
   localparam logic [15:0] IDX_START_OPTS = 16'h140e;
   localparam logic [15:0] IDX_PAUSE_CTRL = 16'h140f;
   localparam logic [15:0] IDX_HOLD_OFF   = 16'h1410;
   localparam int          ADDR_W         = 16;
   localparam int          TW_W           = 32;
   localparam int          ACC_W          = 28;
   // Start option bit positions.
   localparam int          SO_PERSIST     = 0;
   localparam int          SO_SINGLE      = 1;
   localparam int          SO_QUICK       = 2;
   localparam int          SO_WAIT_PHASE  = 3;
   localparam int          SO_WAIT_FREQ   = 4;
   // Pause control bit positions.
   localparam int          PC_PHASE_UNLK  = 0;
   localparam int          PC_FREQ_UNLK   = 1;
   localparam int          PC_SLEWING     = 2;
   localparam logic [4:0]  START_RESET    = 5'h18;
   localparam logic [2:0]  PAUSE_RESET    = 3'h0;
   localparam logic [7:0]  HOLD_RESET     = 8'h00;
   localparam logic [27:0] ACC_RESET      = 28'h000000a;
   // Millisecond tick timing.
   localparam int          CLK_PERIOD_NS  = 10;
   localparam int          MS_TIME_NS     = 1000000;
   localparam int          MS_CYCLES      = MS_TIME_NS / CLK_PERIOD_NS;
   typedef enum logic [2:0] {
      HHQ_IDLE = 3'b001,
      HHQ_HOLD = 3'b010,
      HHQ_RUN  = 3'b100
   } hhq_state_t;
endpackage

//--- sim/hhq_loop_model.sv
// Purpose: Behavioural DPLL loop that supplies lock status and tuning words.
// Assumes: The bench sets the wanted status in cmd; outputs change just after a rising edge.
// Notes:   The tuning word moves every cycle so that a stale capture cannot pass.
`timescale 1ns/1ps
module hhq_loop_model
   import hhq_pkg::*;
(
   input  wire logic            clk,
   input  wire logic [4:0]      cmd,
   output logic                 freqLock,
   output logic                 phaseLock,
   output logic                 slewing,
   output logic                 slewLimit,
   output logic                 holdover,
   output logic [TW_W-1:0]      tuningWord,
   output logic [TW_W-1:0]      avgWord
);
   initial tuningWord = 32'h0;
   initial {holdover, slewLimit, slewing, phaseLock, freqLock} = 5'h0;
   initial avgWord = 32'h0;
   always @(posedge clk) begin
      {holdover, slewLimit, slewing, phaseLock, freqLock} <= cmd;
      tuningWord <= tuningWord + 32'h1;
      avgWord <= ~tuningWord;
   end
endmodule

//--- sim/tb_top.sv
// Purpose: Self-checking bench for the holdover history qualifier.
// Assumes: Millisecond tick shortened to ten cycles.
// Notes:   Status samples are taken at the rising edge, before that edge's updates land.
`timescale 1ns/1ps
module tb_top
   import hhq_pkg::*;
;
   typedef struct packed {logic w; logic [15:0] idx; logic [31:0] d; logic [31:0] expRd; logic expErr;} hhq_row_t;
   logic        clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [15:0] paddr = 16'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd, tw, aw, hoWord;
   logic        pready, pslverr, err, fl, pl, sl, lim, ho, hRun, hPause, hClear, hAvail, useLat;
   logic [4:0]  cmd = 5'h0;
   logic [4:0]  masks [3] = '{5'h04, 5'h08, 5'h01};
   int          mismatches = 0, comparisons = 0, cyc = 0, k;
   wire  [2:0]  mon = {hAvail, hClear, hRun};
   hhq_row_t    rows [13] = '{
      '{1'b0, IDX_START_OPTS, 32'h0, 32'h18, 1'b0}, '{1'b0, IDX_PAUSE_CTRL, 32'h0, 32'h0, 1'b0},
      '{1'b0, IDX_HOLD_OFF, 32'h0, 32'h0, 1'b0}, '{1'b0, IDX_ACC_TIMER, 32'h0, 32'ha, 1'b0},
      '{1'b0, IDX_STATUS, 32'h0, 32'h4, 1'b0}, '{1'b0, 16'h1409, 32'h0, 32'h0, 1'b1},
      '{1'b1, IDX_STATUS, 32'hff, 32'h0, 1'b1}, '{1'b1, IDX_HOLD_OFF, 32'h1ff, 32'h0, 1'b0},
      '{1'b0, IDX_HOLD_OFF, 32'h0, 32'hff, 1'b0}, '{1'b1, IDX_ACC_TIMER, 32'hffffffff, 32'h0, 1'b0},
      '{1'b0, IDX_ACC_TIMER, 32'h0, 32'hfffffff, 1'b0}, '{1'b1, IDX_PAUSE_CTRL, 32'hff, 32'h0, 1'b0},
      '{1'b0, IDX_PAUSE_CTRL, 32'h0, 32'h7, 1'b0}};

   always #5 clk = ~clk;

   hhq_qualifier #(.MsCycles(10)) i_hhq_qualifier (.clk(clk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .freqLockIn(fl), .phaseLockIn(pl), .slewingIn(sl),
      .slewLimitIn(lim), .holdoverIn(ho), .tuningWordIn(tw), .avgWordIn(aw), .histRun(hRun),
      .histPause(hPause), .histClear(hClear), .histAvail(hAvail), .useLatest(useLat),
      .holdoverWord(hoWord));
   hhq_loop_model i_hhq_loop_model (.clk(clk), .cmd(cmd), .freqLock(fl), .phaseLock(pl), .slewing(sl),
      .slewLimit(lim), .holdover(ho), .tuningWord(tw), .avgWord(aw));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= idx << 2;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic waitBit(input int b, input int lim);
      for (k = 0; k < lim && mon[b] !== 1'b1; k++) @(posedge clk);
   endtask

   task automatic end_sim;
      $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // A hang ends the run long after the expected few hundred cycles.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         mismatches++;
         end_sim;
      end
   end

   initial begin
      repeat (12) @(posedge clk);
      chk(mon, 3'h0);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].idx, rows[i].d);
         chk(err, rows[i].expErr);
         if (!rows[i].w) chk(rd, rows[i].expRd);
      end
      apb(1'b1, IDX_ACC_TIMER, 32'h8);
      apb(1'b1, IDX_PAUSE_CTRL, 32'h0);
      apb(1'b1, IDX_HOLD_OFF, 32'h0);
      apb(1'b1, IDX_START_OPTS, 32'h1c);
      cmd <= 5'h02;
      waitBit(0, 20);
      chk(hRun, 1'b0);
      cmd <= 5'h01;
      waitBit(0, 20);
      chk(hRun, 1'b0);
      cmd <= 5'h03;
      waitBit(0, 20);
      chk(k <= 3, 1'b1);
      waitBit(2, 60);
      chk(k >= 10 && k <= 30, 1'b1);
      apb(1'b1, IDX_PAUSE_CTRL, 32'h7);
      foreach (masks[i]) begin
         cmd <= cmd ^ masks[i];
         repeat (2) @(posedge clk);
         chk({hPause, hRun}, 2'h2);
         cmd <= cmd ^ masks[i];
         waitBit(1, 6);
         chk(k < 6, 1'b1);
      end
      // History was just cleared, so holdover must fall back on the latest word.
      apb(1'b1, IDX_START_OPTS, 32'h1e);
      cmd <= 5'h13;
      repeat (3) @(posedge clk);
      chk(useLat, 1'b1);
      chk(hoWord, tw - 32'h1);
      cmd <= 5'h03;
      waitBit(1, 6);
      chk(k < 6, 1'b1);
      apb(1'b1, IDX_HOLD_OFF, 32'h3);
      apb(1'b1, IDX_START_OPTS, 32'h15);
      cmd <= 5'h11;
      repeat (3) @(posedge clk);
      cmd <= 5'h01;
      waitBit(0, 60);
      chk(k >= 25 && k <= 35, 1'b1);
      cmd <= 5'h05;
      repeat (2) @(posedge clk);
      cmd <= 5'h01;
      waitBit(1, 6);
      chk(k, 6);
      apb(1'b1, IDX_PAUSE_CTRL, 32'h3);
      cmd <= 5'h05;
      repeat (2) @(posedge clk);
      chk({hPause, hRun}, 2'h1);
      end_sim;
   end
endmodule
